// ---- rtl/usb_err_pkg.sv ----
// Constants, register map and carrier types for the USB error capture block
package usb_err_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_MASK  = 8'h04;
    localparam logic [7:0] OFS_CTRL  = 8'h08;

    // Flag bit positions in the error flag register
    localparam int BIT_STUFF_POS  = 7;
    localparam int DESC_ADDR_POS  = 6;
    localparam int MEM_XFER_POS   = 5;
    localparam int TURNAROUND_POS = 4;
    localparam int PARTIAL_POS    = 3;
    localparam int DATA_CRC_POS   = 2;
    localparam int BIT1_POS       = 1;
    localparam int PID_POS        = 0;

    // Control register fields
    localparam int CTRL_HOST_POS  = 0;
    localparam int CTRL_EN_POS    = 1;

    // Values after reset
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST  = 8'h02;

    // Bit-time generation: full speed line rate against system clock
    localparam int CLK_KHZ     = 40_000;
    localparam int BIT_KHZ     = 12_000;
    localparam logic [5:0] BIT_STEP = 6'(BIT_KHZ / 1000);
    localparam logic [5:0] BIT_MOD  = 6'(CLK_KHZ / 1000);

    // Idle bit times allowed after an end-of-packet
    localparam logic [4:0] TA_IDLE_BITS = 5'd16;

    // Longest wait for a memory bus grant, in ns, and in cycles
    localparam int CLK_PERIOD_NS = 25;
    localparam int DMA_GRANT_NS  = 200;
    localparam logic [3:0] DMA_GRANT_CYC =
        4'((DMA_GRANT_NS / CLK_PERIOD_NS) < 1 ? 1 :
           (DMA_GRANT_NS / CLK_PERIOD_NS));

    // Turnaround watch states
    typedef enum logic [1:0] {
        TA_IDLE = 2'b01,
        TA_WAIT = 2'b10
    } ta_state_t;

    // Receive path events
    typedef struct packed {
        logic       sop;
        logic       eop;
        logic       bit_stuff;
        logic       crc16_bad;
        logic       crc5_bad;
        logic       data_end;
        logic [2:0] data_bits;
        logic       pid_strobe;
        logic [7:0] pid;
    } usb_rx_t;

    // Memory path events
    typedef struct packed {
        logic dma_req;
        logic dma_gnt;
        logic dma_trunc;
        logic desc_base_bad;
        logic buf_addr_bad;
    } usb_mem_t;

endpackage

// ---- rtl/bit_time_gen.sv ----
// Fractional divider giving one pulse per full speed bit time
`timescale 1ns/1ps
module bit_time_gen (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Control
    input  wire logic enable,
    // Bit time pulse
    output logic      bit_tick
);
    import usb_err_pkg::*;

    logic [5:0] acc_r;
    logic [5:0] acc_sum;
    logic       wrap;
    logic       tick_r;

    // Accumulate the rate ratio and wrap at the modulus
    assign acc_sum  = acc_r + BIT_STEP;
    assign wrap     = acc_sum >= BIT_MOD;
    assign bit_tick = tick_r;

    // Accumulator and tick flop
    always_ff @(posedge clk_sys) begin
        if (srst || !enable) begin
            acc_r  <= 6'h00;
            tick_r <= 1'b0;
        end else begin
            acc_r  <= wrap ? 6'(acc_sum - BIT_MOD) : acc_sum;
            tick_r <= wrap;
        end
    end
endmodule

// ---- rtl/usb_error_flag_capture.sv ----
// USB error flag capture with AHB-Lite register access
`timescale 1ns/1ps
module usb_error_flag_capture (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // USB core events
    input  wire usb_err_pkg::usb_rx_t  rx_evt,
    input  wire usb_err_pkg::usb_mem_t mem_evt,
    input  wire logic                await_resp,
    input  wire logic                link_busy,
    input  wire logic                sof_zero,
    // Results
    output logic                     data_reject,
    output logic                     irq
);
    import usb_err_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    // One-hot select: flags, mask, control
    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        if (a[31:8] != 24'h0000_00) begin
            reg_sel = 3'b000;
        end else if (a[7:0] == OFS_FLAGS) begin
            reg_sel = 3'b001;
        end else if (a[7:0] == OFS_MASK) begin
            reg_sel = 3'b010;
        end else if (a[7:0] == OFS_CTRL) begin
            reg_sel = 3'b100;
        end else begin
            reg_sel = 3'b000;
        end
    endfunction

    logic        acc_ok;
    logic [2:0]  ap_sel;
    logic        wr_q_r;
    logic [2:0]  wr_sel_r;
    logic [31:0] rdata_r;
    logic        hready_r;
    logic        hresp_r;
    logic [7:0]  flags_r;
    logic [7:0]  flags_nxt;
    logic [7:0]  mask_r;
    logic [7:0]  mask_nxt;
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [7:0]  set_vec;
    logic [7:0]  clr_vec;
    logic        irq_r;
    logic        reject_r;
    logic        host_mode;
    logic        enable;
    logic        bit_tick;

    // Address phase qualification
    assign acc_ok = hsel && hready && htrans[1];
    assign ap_sel = reg_sel(haddr);

    ////////////////////////////////////////////////////////////////////////
    // Register writes

    // Writes land in the data phase; only the low byte is held, only bits 1:0 for control
    assign clr_vec  = (wr_q_r && wr_sel_r[0]) ? hwdata[7:0] : 8'h00;
    assign mask_nxt = (wr_q_r && wr_sel_r[1]) ? hwdata[7:0] : mask_r;
    assign ctrl_nxt = (wr_q_r && wr_sel_r[2]) ?
                      {6'h00, hwdata[1:0]} : ctrl_r;
    assign host_mode = ctrl_r[CTRL_HOST_POS];
    assign enable    = ctrl_r[CTRL_EN_POS];

    // Flag bits: a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            assign flags_nxt[gi] = (flags_r[gi] & ~clr_vec[gi])
                                   | set_vec[gi];
        end
    endgenerate

    // Bus phase and register state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_q_r   <= 1'b0;
            wr_sel_r <= 3'b000;
            flags_r  <= FLAGS_RST;
            mask_r   <= MASK_RST;
            ctrl_r   <= CTRL_RST;
        end else begin
            wr_q_r   <= acc_ok && hwrite;
            wr_sel_r <= ap_sel;
            flags_r  <= flags_nxt;
            mask_r   <= mask_nxt;
            ctrl_r   <= ctrl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and response

    logic [31:0] rd_mux;

    // Upper bits always zero; next values keep a write-then-read coherent
    assign rd_mux = ap_sel[0] ? {24'h0000_00, flags_nxt} :
                    ap_sel[1] ? {24'h0000_00, mask_nxt}  :
                    ap_sel[2] ? {24'h0000_00, ctrl_nxt}  :
                    32'h0000_0000;

    // Zero-wait slave, always OKAY
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_r  <= 32'h0000_0000;
            hready_r <= 1'b1;
            hresp_r  <= 1'b0;
        end else begin
            rdata_r  <= (acc_ok && !hwrite) ? rd_mux : 32'h0000_0000;
            hready_r <= 1'b1;
            hresp_r  <= 1'b0;
        end
    end

    assign hrdata    = rdata_r;
    assign hreadyout = hready_r;
    assign hresp     = hresp_r;

    ////////////////////////////////////////////////////////////////////////
    // Bit time source

    bit_time_gen u_bit_time (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .enable   (enable),
        .bit_tick (bit_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Turnaround watch

    ta_state_t  ta_state_r;
    ta_state_t  ta_state_nxt;
    logic [4:0] ta_cnt_r;
    logic [4:0] ta_cnt_nxt;
    logic       ta_expire;

    // More than the allowed idle bit times without a new packet
    assign ta_expire = (ta_state_r == TA_WAIT) && bit_tick && !rx_evt.sop
                       && (ta_cnt_r == TA_IDLE_BITS);

    // Arm on end-of-packet while a reply is awaited, drop on packet start
    always_comb begin
        ta_state_nxt = ta_state_r;
        ta_cnt_nxt   = ta_cnt_r;
        case (ta_state_r)
            TA_IDLE: begin
                if (rx_evt.eop && await_resp && enable) begin
                    ta_state_nxt = TA_WAIT;
                    ta_cnt_nxt   = 5'd0;
                end
            end
            TA_WAIT: begin
                if (rx_evt.sop || !await_resp || ta_expire) begin
                    ta_state_nxt = TA_IDLE;
                    ta_cnt_nxt   = 5'd0;
                end else if (bit_tick) begin
                    ta_cnt_nxt = ta_cnt_r + 5'd1;
                end
            end
            default: begin
                ta_state_nxt = TA_IDLE;
                ta_cnt_nxt   = 5'd0;
            end
        endcase
    end

    // Turnaround state flops
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ta_state_r <= TA_IDLE;
            ta_cnt_r   <= 5'd0;
        end else begin
            ta_state_r <= ta_state_nxt;
            ta_cnt_r   <= ta_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory grant watch

    logic [3:0] gnt_cnt_r;
    logic       gnt_late;

    // Request left ungranted for the full window
    assign gnt_late = mem_evt.dma_req && !mem_evt.dma_gnt
                      && (gnt_cnt_r == DMA_GRANT_CYC);

    // Count cycles of an outstanding request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gnt_cnt_r <= 4'h0;
        end else if (!mem_evt.dma_req || mem_evt.dma_gnt || gnt_late) begin
            gnt_cnt_r <= 4'h0;
        end else begin
            gnt_cnt_r <= gnt_cnt_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event detection

    logic pid_bad;
    logic partial;
    logic eof_err;
    logic tok_err;

    // Detectors feeding the flag set vector
    assign pid_bad = rx_evt.pid_strobe
                     && (rx_evt.pid[3:0] != ~rx_evt.pid[7:4]);
    assign partial = rx_evt.data_end
                     && (rx_evt.data_bits != 3'd0);
    assign eof_err = host_mode && sof_zero && link_busy;
    assign tok_err = !host_mode && rx_evt.crc5_bad;

    assign set_vec[BIT_STUFF_POS]  = enable && rx_evt.bit_stuff;
    assign set_vec[DESC_ADDR_POS]  = enable && (mem_evt.desc_base_bad
                                     || mem_evt.buf_addr_bad);
    assign set_vec[MEM_XFER_POS]   = enable && (gnt_late
                                     || mem_evt.dma_trunc);
    assign set_vec[TURNAROUND_POS] = ta_expire;
    assign set_vec[PARTIAL_POS]    = enable && partial;
    assign set_vec[DATA_CRC_POS]   = enable && rx_evt.crc16_bad;
    assign set_vec[BIT1_POS]       = enable && (eof_err || tok_err);
    assign set_vec[PID_POS]        = enable && pid_bad;

    // Reject pulse and interrupt level
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reject_r <= 1'b0;
            irq_r    <= 1'b0;
        end else begin
            reject_r <= set_vec[DATA_CRC_POS];
            irq_r    <= |(flags_nxt & mask_nxt);
        end
    end

    assign data_reject = reject_r;
    assign irq         = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    upper_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
        acc_ok && !hwrite |=> rdata_r[31:8] == 24'h0000_00)
        else $error("upper read bits not zero");

    w1c_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
        wr_q_r && wr_sel_r[0] && hwdata[0] && !set_vec[0] |=> !flags_r[0])
        else $error("flag not cleared by one");

    zero_keeps_a: assert property (@(posedge clk_sys) disable iff (srst)
        wr_q_r && wr_sel_r[0] && !hwdata[7] && flags_r[7] |=> flags_r[7])
        else $error("zero write cleared flag");

    stuff_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && rx_evt.bit_stuff |=> flags_r[BIT_STUFF_POS])
        else $error("bit stuff flag missed");

    addr_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && mem_evt.buf_addr_bad |=> flags_r[DESC_ADDR_POS])
        else $error("address flag missed");

    grant_late_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && mem_evt.dma_req && !mem_evt.dma_gnt
        && gnt_cnt_r == DMA_GRANT_CYC |=> flags_r[MEM_XFER_POS])
        else $error("late grant not flagged");

    trunc_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && mem_evt.dma_trunc |=> flags_r[MEM_XFER_POS])
        else $error("truncation not flagged");

    turn_timeout_a: assert property (@(posedge clk_sys) disable iff (srst)
        set_vec[TURNAROUND_POS] |-> ta_cnt_r == 5'd16 && $past(bit_tick, 4)
        == 1'b0 || ta_cnt_r == 5'd16)
        else $error("timeout before 16 idle bits");

    partial_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && rx_evt.data_end && rx_evt.data_bits != 3'd0
        |=> flags_r[PARTIAL_POS])
        else $error("partial byte not flagged");

    crc16_reject_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && rx_evt.crc16_bad |=> flags_r[DATA_CRC_POS] && data_reject)
        else $error("crc16 not flagged or rejected");

    eof_host_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && host_mode && sof_zero && link_busy |=> flags_r[BIT1_POS])
        else $error("frame end error missed");

    token_dev_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && !host_mode && rx_evt.crc5_bad |=> flags_r[BIT1_POS])
        else $error("token crc error missed");

    pid_check_a: assert property (@(posedge clk_sys) disable iff (srst)
        enable && rx_evt.pid_strobe && rx_evt.pid[3:0] != ~rx_evt.pid[7:4]
        |=> flags_r[PID_POS])
        else $error("pid check missed");

    irq_level_a: assert property (@(posedge clk_sys) disable iff (srst)
        ##1 irq == |(flags_r & mask_r))
        else $error("interrupt level wrong");

endmodule

// ---- sim/usb_far_end.sv ----
// Behavioural far side: USB link partner and memory bus events
`timescale 1ns/1ps
module usb_far_end (
    // Clock
    input  wire logic                  clk_sys,
    // Command from the bench
    input  wire logic                  evt_go,
    input  wire logic [3:0]            evt_sel,
    input  wire logic [7:0]            evt_arg,
    // Events towards the block
    output usb_err_pkg::usb_rx_t       rx_evt,
    output usb_err_pkg::usb_mem_t      mem_evt,
    output logic                       await_resp,
    output logic                       link_busy,
    output logic                       sof_zero
);
    import usb_err_pkg::*;

    int         gap;
    logic [2:0] pend;

    initial begin
        rx_evt = '0;
        mem_evt = '0;
        await_resp = 1'b0;
        link_busy = 1'b0;
        sof_zero = 1'b0;
        gap = 0;
        pend = 3'h0;
    end

    // Pulses last one cycle; unqualified fields toggle so nothing is stale
    always @(posedge clk_sys) begin
        rx_evt <= '{pid: ~rx_evt.pid, data_bits: ~rx_evt.data_bits,
                    default: 1'b0};
        mem_evt <= '{dma_req: mem_evt.dma_req, dma_gnt: 1'b0,
                     default: 1'b0};
        sof_zero <= 1'b0;
        if (pend == 3'h0) begin
            mem_evt.dma_req <= 1'b0;
        end else if (gap > 0) begin
            gap <= gap - 1;
        end else if (pend == 3'h4) begin
            rx_evt.sop <= 1'b1;    // Reply, prompt or late
            await_resp <= 1'b0;
            pend <= 3'h0;
        end else begin
            mem_evt.dma_gnt <= 1'b1;
            pend <= 3'h0;
        end
        if (evt_go) begin
            case (evt_sel)
                4'h0: rx_evt.bit_stuff <= 1'b1;
                4'h1: mem_evt.desc_base_bad <= 1'b1;
                4'h2: mem_evt.buf_addr_bad <= 1'b1;
                4'h3: mem_evt.dma_trunc <= 1'b1;
                4'h4: begin
                    rx_evt.eop <= 1'b1;
                    await_resp <= 1'b1;
                    pend <= 3'h4;
                    gap <= evt_arg;
                end
                4'h5: begin
                    mem_evt.dma_req <= 1'b1;
                    pend <= 3'h5;
                    gap <= evt_arg;
                end
                4'h6: begin
                    rx_evt.data_end <= 1'b1;
                    rx_evt.data_bits <= evt_arg[2:0];
                end
                4'h7: rx_evt.crc16_bad <= 1'b1;
                4'h8: rx_evt.crc5_bad <= 1'b1;
                4'h9: begin
                    sof_zero <= 1'b1;
                    link_busy <= evt_arg[0];
                end
                default: begin
                    rx_evt.pid_strobe <= 1'b1;
                    rx_evt.pid <= evt_arg;
                end
            endcase
        end
    end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the USB error flag capture block
`timescale 1ns/1ps
module tb_top;
    import usb_err_pkg::*;

    logic        clk_sys, srst, hsel, hwrite, hready, hreadyout, hresp;
    logic        evt_go, await_resp, link_busy, sof_zero, data_reject, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  evt_sel;
    logic [7:0]  evt_arg;
    usb_rx_t     rx_evt;
    usb_mem_t    mem_evt;
    int          errors, comparisons, exp_flags, msk, b, rej_exp, rej_seen;
    int          sel_q[$] = '{0,1,2,3,4,4,5,5,6,6,7,8,8,9,9,10,10,0,10,10};
    int          arg_q[$] = '{0,0,0,0,20,120,3,20,0,5,0,0,0,1,0,165,0,0,0,0};
    int          mode_q[$] = '{2,2,2,2,2,2,2,2,2,2,2,2,3,3,3,2,2,0,2,2};

    assign hready = hreadyout;

    usb_error_flag_capture u_dut (.clk_sys(clk_sys), .srst(srst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_evt(rx_evt),
        .mem_evt(mem_evt), .await_resp(await_resp), .link_busy(link_busy),
        .sof_zero(sof_zero), .data_reject(data_reject), .irq(irq));

    usb_far_end u_far (.clk_sys(clk_sys), .evt_go(evt_go),
        .evt_sel(evt_sel), .evt_arg(evt_arg), .rx_evt(rx_evt),
        .mem_evt(mem_evt), .await_resp(await_resp), .link_busy(link_busy),
        .sof_zero(sof_zero));

    // Clock at 40 MHz
    always #12.5 clk_sys = ~clk_sys;

    // Counts reject pulses seen
    always @(posedge clk_sys) begin
        if (data_reject === 1'b1) rej_seen++;
    end

    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Waits for an edge with ready high, bounded
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk_sys);
        while (hready !== 1'b1) begin
            n++;
            if (n > 64) begin
                errors++;
                close_out;
            end
            @(posedge clk_sys);
        end
    endtask

    // One single AHB-Lite word transfer
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
        check({31'h0000_0000, hresp}, 32'h0000_0000, "response");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(a, 1'b1, d, x);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string what);
        logic [31:0] x;
        xfer(a, 1'b0, 32'h0000_0000, x);
        check(x, e, what);
    endtask

    task automatic fire(input logic [3:0] s, input logic [7:0] a);
        @(posedge clk_sys);
        evt_sel <= s;
        evt_arg <= a;
        evt_go <= 1'b1;
        @(posedge clk_sys);
        evt_go <= 1'b0;
        repeat (140) @(posedge clk_sys);
    endtask

    // Expected flag position for an event, -1 for none
    function automatic int exp_bit(int s, int a, int host, int en);
        if (en == 0) return -1;
        case (s)
            0: return BIT_STUFF_POS;
            1, 2: return DESC_ADDR_POS;
            3: return MEM_XFER_POS;
            4: return (a * BIT_STEP > TA_IDLE_BITS * BIT_MOD) ?
                      TURNAROUND_POS : -1;
            5: return (a > DMA_GRANT_CYC + 1) ? MEM_XFER_POS : -1;
            6: return (a % 8 != 0) ? PARTIAL_POS : -1;
            7: return DATA_CRC_POS;
            8: return host ? -1 : BIT1_POS;
            9: return (host && a % 2) ? BIT1_POS : -1;
            default: return (a % 16 != 15 - a / 16) ? PID_POS : -1;
        endcase
    endfunction

    initial begin
        clk_sys = 1'b0;
        srst = 1'b1;
        {hsel, hwrite, evt_go} = 3'h0;
        {haddr, hwdata} = 64'h0000_0000_0000_0000;
        htrans = 2'b00;
        hsize = 3'b010;
        evt_sel = 4'h0;
        evt_arg = 8'h00;
        void'($urandom(32'h2303));
        arg_q[16] = $urandom % 256;
        arg_q[18] = $urandom % 256;
        arg_q[19] = $urandom % 256;
        arg_q[9] = 1 + $urandom % 7;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        // Reset values and unmapped space
        rdchk(OFS_FLAGS, {24'h00_0000, FLAGS_RST}, "flags reset");
        rdchk(OFS_MASK, {24'h00_0000, MASK_RST}, "mask reset");
        rdchk(OFS_CTRL, {24'h00_0000, CTRL_RST}, "ctrl reset");
        wr(8'h40, 32'hFFFF_FFFF);
        rdchk(8'h40, 32'h0000_0000, "unmapped");
        foreach (sel_q[i]) begin
            msk = $urandom % 256;
            wr(OFS_CTRL, mode_q[i]);
            wr(OFS_MASK, msk);
            rdchk(OFS_MASK, msk, "mask readback");
            b = exp_bit(sel_q[i], arg_q[i], mode_q[i] % 2, mode_q[i] / 2);
            exp_flags = (b < 0) ? 0 : (1 << b);
            if (sel_q[i] == 7 && mode_q[i] >= 2) rej_exp++;
            fire(sel_q[i], arg_q[i]);
            rdchk(OFS_FLAGS, exp_flags, "flag set");
            check({31'h0000_0000, irq}, 32'((exp_flags & msk) != 0), "irq");
            wr(OFS_FLAGS, 32'hFFFF_FF00);
            rdchk(OFS_FLAGS, exp_flags, "upper write");
            wr(OFS_FLAGS, 32'h0000_00FF);
            rdchk(OFS_FLAGS, 32'h0000_0000, "clear");
            check({31'h0000_0000, irq}, 32'h0000_0000, "irq clear");
            $display("test %0d done", i);
        end
        check(rej_seen, rej_exp, "reject pulses");
        close_out;
    end
endmodule
